// ### include/can_mode_params.svh
// timing, offsets and reset values of the transceiver mode controller
// assumes a 200 MHz core clock; all times are given in microseconds
`ifndef CAN_MODE_PARAMS_SVH
`define CAN_MODE_PARAMS_SVH

// ==========================================================
// clock and times
`define CLK_MHZ         200
`define CTRL_OSC_KHZ    100
`define SETTLE_MAX_US   80
`define RST_EXT_MIN_US  20000
`define BUS_IDLE_US     1000
`define DOM_TIMEOUT_US  2000
`define WAKE_PH_US      1
`define WAKE_WIN_US     1000

// ==========================================================
// register map
`define CTRL_OFS        4'h0
`define STAT_OFS        4'h4
`define CTRL_RST        32'h0000_0003
`define CTRL_DOM_EN_BIT 0
`define CTRL_WAKE_EN_BIT 1
`define STAT_WAKE_BIT   4
`define STAT_DOMTO_BIT  5
`define STAT_READY_BIT  6
`define STAT_UV_BIT     7

`endif

// ### include/can_mode_pkg.sv
// state types shared by the mode controller and the wake detector
// assumes nothing of its surroundings
package can_mode_pkg;
    typedef enum logic [1:0] {st_normal, st_standby, st_reset, st_overheat} dev_state_e;
    typedef enum logic [1:0] {bus_active, bus_offline, bus_offbias, bus_off} bus_state_e;
    typedef enum logic [1:0] {bias_zero, bias_half_reg, bias_half_int} bias_e;
    typedef enum logic [1:0] {wk_idle, wk_dom1, wk_rec, wk_dom2} wake_state_e;
endpackage

// ### include/wake_if.sv
// link between the mode controller and the remote wake-up detector
// assumes both ends run on the same clock
interface wake_if;
    logic enable;
    logic bus_dom;
    logic detected;
    modport det (input enable, input bus_dom, output detected);
    modport ctl (output enable, output bus_dom, input detected);
endinterface

// ### src/wake_pattern_det.sv
// remote wake-up pattern detector: dominant, recessive, dominant phases
// assumes bus_dom is already synchronised to clk
`include "can_mode_params.svh"
module wake_pattern_det
    import can_mode_pkg::*;
#(
    parameter int unsigned PH_CYC  = `WAKE_PH_US * `CLK_MHZ,
    parameter int unsigned WIN_CYC = `WAKE_WIN_US * `CLK_MHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // controller side
    wake_if.det      w
);
    wake_state_e st_reg;
    wake_state_e st_next;
    logic [31:0] ph_reg;
    logic [31:0] win_reg;
    logic        prev_reg;

    // ==========================================================
    // phase and window measurement
    wire ph_ok   = ph_reg >= PH_CYC;
    wire win_exp = win_reg >= WIN_CYC - 1;
    wire dom     = w.bus_dom;

    assign w.detected = (st_reg == wk_dom2) && dom && ph_ok && w.enable && !win_exp;

    // ==========================================================
    // pattern sequencer
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            wk_idle: if (dom) st_next = wk_dom1;
            wk_dom1: if (!dom) st_next = ph_ok ? wk_rec : wk_idle;
            wk_rec:  if (dom) st_next = ph_ok ? wk_dom2 : wk_idle;
            wk_dom2: if (ph_ok || !dom) st_next = wk_idle;
        endcase
        // a stale partial pattern is thrown away and the search restarts
        if (!w.enable || (st_reg != wk_idle && win_exp)) st_next = wk_idle;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg   <= wk_idle;
            ph_reg   <= 32'h0000_0000;
            win_reg  <= 32'h0000_0000;
            prev_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            prev_reg <= dom;
            ph_reg   <= (dom != prev_reg) ? 32'h0000_0000 : ph_reg + 32'h0000_0001;
            win_reg  <= (st_next == wk_idle) ? 32'h0000_0000 : win_reg + 32'h0000_0001;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_WAKE_WINDOW: assert property (st_reg != wk_idle |-> win_reg < WIN_CYC)
        else $error("wake pattern outlived its window");
    AST_WAKE_PHASE: assert property (w.detected |-> ph_reg >= PH_CYC && $past(st_reg) != wk_idle)
        else $error("wake reported with a short final phase");
endmodule // wake_pattern_det

// ### src/can_mode_ctrl.sv
// mode and supervision logic of a CAN FD transceiver with regulator
// assumes analog comparators for under-voltage and over-temperature, a
// bus receiver giving bus_dominant_in, and a host on the register port
`include "can_mode_params.svh"

module can_mode_ctrl
    import can_mode_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = `SETTLE_MAX_US * `CLK_MHZ,
    parameter int unsigned RST_EXT_CYC = `RST_EXT_MIN_US * `CLK_MHZ,
    parameter int unsigned IDLE_CYC    = `BUS_IDLE_US * `CLK_MHZ,
    parameter int unsigned DOM_CYC     = `DOM_TIMEOUT_US * `CLK_MHZ,
    parameter int unsigned WAKE_PH_CYC = `WAKE_PH_US * `CLK_MHZ,
    parameter int unsigned WAKE_WIN_CYC = `WAKE_WIN_US * `CLK_MHZ
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // host pins
    input  wire logic        mode_select_n,
    input  wire logic        transmit_data_in,
    output logic             receive_data_out,
    output logic             transceiver_ready_out,
    // open-drain reset line
    input  wire logic        reset_line_n_in,
    output logic             reset_line_n_out,
    output logic             reset_line_n_oe,
    // analog front end
    input  wire logic        bus_dominant_in,
    input  wire logic        regulator_uv_in,
    input  wire logic        over_temp_in,
    output logic             driver_enable_out,
    output logic             driver_dominant_out,
    output logic             hs_receiver_enable,
    output logic             lp_receiver_enable,
    output logic             regulator_enable,
    output logic             bus_float_out,
    output logic [1:0]       bias_midpoint,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);
    // ==========================================================
    // input synchronisers
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    wire  [5:0] raw = {over_temp_in, regulator_uv_in, bus_dominant_in,
                       transmit_data_in, reset_line_n_in, mode_select_n};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_reg <= 6'h00;
            s2_reg <= 6'h00;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
        end
    end

    wire mode_s  = s2_reg[0];
    wire rstn_s  = s2_reg[1];
    wire txd_s   = s2_reg[2];
    wire bdom_s  = s2_reg[3];
    // the 4.3 V threshold sits in the comparator; only its verdict arrives here
    wire uv_s    = s2_reg[4];
    wire ot_s    = s2_reg[5];

    // ==========================================================
    // state registers
    dev_state_e  dev_reg;
    dev_state_e  dev_next;
    bus_state_e  bus_reg;
    bus_state_e  bus_next;
    logic [31:0] settle_reg;
    logic [31:0] ext_reg;
    logic [31:0] idle_reg;
    logic [31:0] dom_reg;
    logic        arm_reg;
    logic        dom_to_reg;
    logic        wake_flag_reg;
    logic        rxd_reg;
    logic        ready_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] rdata_reg;
    logic        wake_det;

    wire in_active  = bus_reg == bus_active;
    wire in_offline = bus_reg == bus_offline;
    wire in_offbias = bus_reg == bus_offbias;
    wire in_standby = in_offline || in_offbias;
    wire dom_en     = ctrl_reg[`CTRL_DOM_EN_BIT];
    wire wake_en    = ctrl_reg[`CTRL_WAKE_EN_BIT];

    // ==========================================================
    // reset line
    wire rst_cause = uv_s || ot_s || dev_reg == st_overheat;
    wire rst_drive = rst_cause || ext_reg != 32'h0000_0000;

    assign reset_line_n_out = 1'b0;
    assign reset_line_n_oe  = rst_drive;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_reg <= RST_EXT_CYC;
        end else if (rst_cause) begin
            ext_reg <= RST_EXT_CYC;
        end else if (ext_reg != 32'h0000_0000) begin
            ext_reg <= ext_reg - 32'h0000_0001;
        end
    end

    // ==========================================================
    // device state machine
    always_comb begin
        dev_next = dev_reg;
        unique case (dev_reg)
            st_normal, st_standby: begin
                if (!rstn_s) dev_next = st_reset;
                else dev_next = mode_s ? st_normal : st_standby;
            end
            st_reset:    if (rstn_s) dev_next = mode_s ? st_normal : st_standby;
            st_overheat: dev_next = st_reset;
        endcase
        if (ot_s) dev_next = st_overheat;
    end

    // ==========================================================
    // bus state machine
    wire idle_exp    = idle_reg >= IDLE_CYC;
    wire settle_done = settle_reg >= SETTLE_CYC - 1;

    always_comb begin
        bus_next = bus_reg;
        unique case (bus_reg)
            bus_off: bus_next = bus_offline;
            bus_active: begin
                if (dev_reg == st_standby)
                    bus_next = idle_exp ? bus_offline : bus_offbias;
            end
            bus_offline: begin
                if (dev_reg == st_normal && settle_done) bus_next = bus_active;
                else if (wake_det) bus_next = bus_offbias;
            end
            bus_offbias: begin
                if (dev_reg == st_normal && settle_done) bus_next = bus_active;
                else if (idle_exp) bus_next = bus_offline;
            end
        endcase
        if (dev_reg == st_reset || dev_reg == st_overheat) bus_next = bus_off;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dev_reg <= st_reset;
            bus_reg <= bus_off;
        end else begin
            dev_reg <= dev_next;
            bus_reg <= bus_next;
        end
    end

    // analog enable time before the bus goes active
    always_ff @(posedge clk) begin
        if (!nrst || dev_reg != st_normal || in_active || bus_reg == bus_off) begin
            settle_reg <= 32'h0000_0000;
        end else if (!settle_done) begin
            settle_reg <= settle_reg + 32'h0000_0001;
        end
    end

    // ==========================================================
    // bus idle timer, cleared by any dominant level
    always_ff @(posedge clk) begin
        if (!nrst || !(in_active || in_offbias) || bdom_s) begin
            idle_reg <= 32'h0000_0000;
        end else if (!idle_exp) begin
            idle_reg <= idle_reg + 32'h0000_0001;
        end
    end

    // ==========================================================
    // transmit gating and dominant timeout
    always_ff @(posedge clk) begin
        if (!nrst || !in_active) begin
            arm_reg    <= 1'b0;
            dom_reg    <= 32'h0000_0000;
            dom_to_reg <= 1'b0;
        end else if (txd_s) begin
            arm_reg    <= 1'b1;
            dom_reg    <= 32'h0000_0000;
            dom_to_reg <= 1'b0;
        end else begin
            if (dom_reg < DOM_CYC) dom_reg <= dom_reg + 32'h0000_0001;
            if (dom_en && dom_reg >= DOM_CYC - 1) dom_to_reg <= 1'b1;
        end
    end

    // transmit level goes straight to the driver so bit timing sees no latency
    assign driver_enable_out   = in_active && arm_reg && !dom_to_reg;
    assign driver_dominant_out = driver_enable_out && !transmit_data_in;

    // ==========================================================
    // receive output and ready
    always_ff @(posedge clk) begin
        if (!nrst || in_active) begin
            wake_flag_reg <= 1'b0;
        end else if (wake_det) begin
            wake_flag_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rxd_reg   <= 1'b1;
            ready_reg <= 1'b0;
        end else begin
            rxd_reg   <= in_active ? !bdom_s : !(in_standby && (wake_flag_reg || wake_det));
            ready_reg <= dev_reg == st_normal && in_active && !uv_s && !dom_to_reg;
        end
    end

    assign receive_data_out      = rxd_reg;
    assign transceiver_ready_out = ready_reg;

    // ==========================================================
    // analog enables
    assign hs_receiver_enable = in_active;
    assign lp_receiver_enable = in_standby;
    // the regulator stays up through reset so that under-voltage can recover
    assign regulator_enable   = dev_reg != st_overheat;
    assign bus_float_out      = bus_reg == bus_off;
    assign bias_midpoint      = in_active ? bias_half_reg : (in_offbias ? bias_half_int : bias_zero);

    // ==========================================================
    // wake-up detector
    wake_if wif ();
    assign wif.enable  = in_standby && wake_en;
    assign wif.bus_dom = bdom_s;
    assign wake_det    = wif.detected;

    wake_pattern_det #(
        .PH_CYC  (WAKE_PH_CYC),
        .WIN_CYC (WAKE_WIN_CYC)
    ) u_wake (
        .clk  (clk),
        .nrst (nrst),
        .w    (wif.det)
    );

    // ==========================================================
    // register port
    wire sel_ctrl = reg_addr == `CTRL_OFS;
    wire sel_stat = reg_addr == `STAT_OFS;
    wire [31:0] stat_word = {24'h00_0000, uv_s, ready_reg, dom_to_reg, wake_flag_reg,
                             bus_reg, dev_reg};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_reg : (sel_stat ? stat_word : 32'h0000_0000);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_reg  <= `CTRL_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (reg_wr && sel_ctrl) ctrl_reg <= {30'h0000_0000, reg_wdata[1:0]};
            rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_enter_active;
        in_active && $past(bus_reg) != bus_active;
    endsequence

    AST_ARM_FIRST: assert property (s_enter_active |-> !driver_enable_out)
        else $error("driver enabled on entry to active");
    AST_DOM_CUT: assert property (dom_to_reg |-> !driver_enable_out ##1 !transceiver_ready_out)
        else $error("driver on during dominant timeout");
    AST_RXD_NORMAL: assert property ($past(in_active) |-> receive_data_out == !$past(bdom_s))
        else $error("receive output does not follow bus");
    AST_RXD_LATCH: assert property (in_standby && wake_flag_reg |=> !receive_data_out)
        else $error("wake indication lost in standby");
    AST_READY_ONLY_ACTIVE: assert property (transceiver_ready_out |-> $past(dev_reg) == st_normal && $past(in_active))
        else $error("ready outside normal active");
    AST_UV_DRIVES: assert property (uv_s |-> reset_line_n_oe ##1 !transceiver_ready_out)
        else $error("under-voltage did not pull reset");
    AST_EXT_HOLD: assert property ($fell(rst_cause) |-> reset_line_n_oe [*8])
        else $error("reset line released without extension");
    AST_OT_ENTER: assert property (ot_s |=> dev_reg == st_overheat ##1 bus_reg == bus_off)
        else $error("over-temperature not handled");
    AST_BUS_MAP: assert property (in_active |-> $past(dev_reg) == st_normal)
        else $error("bus active outside normal");
    AST_IDLE_STOP: assert property (in_offline || bus_reg == bus_off |=> idle_reg == 32'h0000_0000 || in_active || in_offbias)
        else $error("idle timer ran while stopped");
    AST_STBY_EXIT: assert property (in_active && dev_reg == st_standby |=> (in_offline || in_offbias))
        else $error("active did not leave on standby");
    AST_RST_ENTER: assert property (!rstn_s && (dev_reg == st_normal || dev_reg == st_standby) && !ot_s |=> dev_reg == st_reset ##1 bus_reg == bus_off)
        else $error("reset line low not obeyed");
endmodule // can_mode_ctrl

// ### sim/can_bus_model.sv
// bus model: other nodes on the bus and the pulled-up reset wire
// assumes the controller drives the reset wire open-drain
module can_bus_model (
    // clock
    input  wire logic clk,
    // device side
    input  wire logic driver_dominant_out,
    input  wire logic reset_line_n_out,
    input  wire logic reset_line_n_oe,
    // other parties
    input  wire logic ext_pull,
    output logic      bus_dominant_in,
    output logic      reset_line_n_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic node_dom = 1'b0;

    // ==========================================================
    // wired bus and reset line
    // dominant wins over recessive, so any driver shows on the bus
    assign bus_dominant_in = driver_dominant_out | node_dom;
    // pull-up wins only while nobody pulls low
    assign reset_line_n_in = (reset_line_n_oe ? reset_line_n_out : 1'b1) & ~ext_pull;

    // ==========================================================
    // wake-up pattern from a remote node
    task automatic pattern(input int d1, input int r1, input int d2);
        @(posedge clk) node_dom <= 1'b1;
        repeat (d1) @(posedge clk);
        node_dom <= 1'b0;
        repeat (r1) @(posedge clk);
        node_dom <= 1'b1;
        repeat (d2) @(posedge clk);
        node_dom <= 1'b0;
    endtask
endmodule // can_bus_model

// ### sim/can_mode_ctrl_tb.sv
// testbench of the transceiver mode controller
// assumes shortened counts and the bus model beside it
module can_mode_ctrl_tb
    import can_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SET = 20, EXT = 50, IDLE = 100, DOM = 40;
    logic clk = 0, nrst = 0, msel_n = 0, tx = 1, uv = 0, ot = 0, ext_pull = 0, wr_s = 0, rd_s = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdv, rdata;
    logic rxd, rdy, rl_out, rl_oe, rl_in, bus_dom, drv_en, drv_dom, reg_en, flt, hs_en, lp_en;
    logic [1:0] bias;
    int bad_count = 0, n_checks = 0;

    always #2.5 clk = ~clk;

    can_mode_ctrl #(.SETTLE_CYC(SET), .RST_EXT_CYC(EXT), .IDLE_CYC(IDLE), .DOM_CYC(DOM),
        .WAKE_PH_CYC(4), .WAKE_WIN_CYC(60)) DUT (
        .clk(clk), .nrst(nrst), .mode_select_n(msel_n), .transmit_data_in(tx),
        .receive_data_out(rxd), .transceiver_ready_out(rdy), .reset_line_n_in(rl_in),
        .reset_line_n_out(rl_out), .reset_line_n_oe(rl_oe), .bus_dominant_in(bus_dom),
        .regulator_uv_in(uv), .over_temp_in(ot), .driver_enable_out(drv_en),
        .driver_dominant_out(drv_dom), .hs_receiver_enable(hs_en), .lp_receiver_enable(lp_en),
        .regulator_enable(reg_en), .bus_float_out(flt), .bias_midpoint(bias),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata));

    can_bus_model u_bus (.clk(clk), .driver_dominant_out(drv_dom), .reset_line_n_out(rl_out),
        .reset_line_n_oe(rl_oe), .ext_pull(ext_pull), .bus_dominant_in(bus_dom), .reset_line_n_in(rl_in));

    // ==========================================================
    // access tasks
    task automatic summarize();
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_s  <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask

    task automatic st(input logic [3:0] e);
        rd(4'h4, rdv);
        ck("state", e, rdv[3:0]);
    endtask

    // polls status; a state never reached ends the run
    task automatic wait_st(input logic [3:0] e, input int lim);
        int i;
        rd(4'h4, rdv);
        for (i = 0; i < lim && rdv[3:0] !== e; i++) rd(4'h4, rdv);
        ck("state", e, rdv[3:0]);
        if (rdv[3:0] !== e) summarize();
    endtask

    // ==========================================================
    // sequence
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        st({bus_off, st_reset});
        rd(4'h0, rdv); ck("ctrl", 32'h0000_0003, rdv);
        rd(4'hC, rdv); ck("unmapped", 32'h0000_0000, rdv);
        repeat (EXT - 20) @(posedge clk);
        @(negedge clk) ck("rst oe", 1, rl_oe);
        wait_st({bus_offline, st_standby}, 40);
        @(negedge clk) ck("rxd", 1, rxd); ck("ready", 0, rdy);
        ck("lp rx", 1, lp_en); ck("hs rx", 0, hs_en);
        u_bus.pattern(35, 35, 35);
        rd(4'h4, rdv); ck("wake", 0, rdv[4]);
        wr(4'h0, 32'h0000_0000);
        u_bus.pattern(10, 10, 10);
        rd(4'h4, rdv); ck("wake off", 0, rdv[4]);
        wr(4'h0, 32'hFFFF_FFFF);
        rd(4'h0, rdv); ck("ctrl", 32'h0000_0003, rdv);
        u_bus.pattern(10, 10, 10);
        st({bus_offbias, st_standby}); ck("wake", 1, rdv[4]);
        @(negedge clk) ck("rxd", 0, rxd); ck("bias", 2, bias);
        repeat (IDLE - 30) @(posedge clk);
        st({bus_offbias, st_standby});
        wait_st({bus_offline, st_standby}, 40);
        @(negedge clk) ck("rxd", 0, rxd);
        // dominant request during entry must not reach the bus
        @(posedge clk) tx <= 1'b0;
        msel_n <= 1'b1;
        wait_st({bus_active, st_normal}, SET);
        ck("drv", 0, drv_en); ck("bias", 1, bias); ck("hs rx", 1, hs_en);
        @(negedge clk) ck("rxd", 1, rxd);
        // the wake latch clears on the first active edge, so read status again
        rd(4'h4, rdv); ck("wake", 0, rdv[4]);
        @(posedge clk) tx <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk) ck("drv", 1, drv_en); ck("ready", 1, rdy);
        @(posedge clk) tx <= 1'b0;
        @(negedge clk) ck("dom", 1, drv_dom);
        repeat (4) @(posedge clk);
        @(negedge clk) ck("rxd", 0, rxd);
        repeat (DOM + 4) @(posedge clk);
        @(negedge clk) ck("drv", 0, drv_en); ck("ready", 0, rdy);
        rd(4'h4, rdv); ck("timeout", 6'h20, rdv[5:0]);
        @(posedge clk) tx <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk) ck("drv", 1, drv_en); ck("rxd", 1, rxd);
        @(posedge clk) msel_n <= 1'b0;
        repeat (6) @(posedge clk);
        st({bus_offbias, st_standby}); ck("ready", 0, rdy);
        wait_st({bus_offline, st_standby}, IDLE);
        @(posedge clk) msel_n <= 1'b1;
        wait_st({bus_active, st_normal}, SET);
        repeat (IDLE + 10) @(posedge clk);
        msel_n <= 1'b0;
        repeat (6) @(posedge clk);
        st({bus_offline, st_standby});
        @(posedge clk) uv <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk) ck("uv oe", 1, rl_oe); ck("float", 1, flt);
        ck("rx en", 0, {hs_en, lp_en}); ck("rst out", 0, rl_out);
        rd(4'h4, rdv); ck("uv status", 8'h8E, rdv[7:0]);
        @(posedge clk) uv <= 1'b0;
        repeat (EXT - 20) @(posedge clk);
        @(negedge clk) ck("rst oe", 1, rl_oe);
        wait_st({bus_offline, st_standby}, 40);
        @(posedge clk) ext_pull <= 1'b1;
        repeat (6) @(posedge clk);
        st({bus_off, st_reset});
        @(posedge clk) ext_pull <= 1'b0;
        wait_st({bus_offline, st_standby}, 20);
        @(posedge clk) ot <= 1'b1;
        repeat (6) @(posedge clk);
        st({bus_off, st_overheat}); ck("reg en", 0, reg_en); ck("ot oe", 1, rl_oe);
        @(posedge clk) ot <= 1'b0;
        repeat (6) @(posedge clk);
        st({bus_off, st_reset});
        wait_st({bus_offline, st_standby}, EXT);
        summarize();
    end
endmodule // can_mode_ctrl_tb
